// file: inc/ssc_pkg.sv
// ssc_pkg: constants shared by the step sequencer and its excitation table.
// assumes one 125 MHz clock domain; every pin is synchronised inside ssc_seq.
// Functional notes
// (RULE1) power-on reset puts outputs at home state
// (RULE2) reset input re-homes the running sequencer
// (RULE3) unused reset input is held low externally
// (RULE4) one sequence increment per active clock edge
// (RULE5) rising edges only, or both on double-edge
// (RULE6) stopped clock holds state, level irrelevant
// (RULE7) chop sync input high enables synchronized chopping
// (RULE8) controller keeps chop sync off while rotating
// (RULE9) chop sync may derive from clock timeout
// (RULE10) controller inverts a clock resting high; ssc_mcu_model never inverts step_clk_o
// (RULE11) reference above 2 V coasts, sequencer keeps stepping
// (RULE12) all mode selects high coasts and freezes
// (RULE13) enable/disable decision switches near 1.75 V
// (RULE14) controller waits after sleep before stepping
// (RULE15) double-edge: first edge after sleep may fall
// (RULE16) controller ties unused logic inputs, never floating
// (RULE17) monitor and fault outputs are push-pull
// (RULE18) direction picks forward or backward stepping
// (RULE19) mode selects pick resolution; all-high means sleep
package ssc_pkg;
   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STEPS = 4'h8;
   // control bits
   localparam int CTRL_REHOME_BIT = 0;
   localparam int CTRL_COAST_BIT = 1;
   // status layout
   localparam int ST_POS_LSB = 0;
   localparam int ST_SLEEP_REF_DISABLE_BIT = 8;
   localparam int ST_SLEEP_MODE_PINS_DISABLE_BIT = 9;
   localparam int ST_COAST_BIT = 10;
   localparam int ST_DIR_BIT = 11;
   localparam int ST_MODE_LSB = 12;
   localparam int ST_CHOP_BIT = 16;
   localparam int ST_FAULT_BIT = 17;
   localparam int ST_HOME_BIT = 18;
   // sequencer position: 64 sixteenth-steps per electrical cycle
   localparam int POS_W = 6;
   localparam logic [POS_W-1:0] HOME_POS = 6'h08;
   localparam int LVL_W = 4;
   localparam int STEP_CNT_W = 16;
   // step mode select codes
   localparam logic [2:0] MODE_FULL = 3'h0;
   localparam logic [2:0] MODE_HALF = 3'h1;
   localparam logic [2:0] MODE_QUARTER = 3'h2;
   localparam logic [2:0] MODE_EIGHTH = 3'h3;
   localparam logic [2:0] MODE_SIXTEENTH = 3'h4;
   localparam logic [2:0] MODE_FULL_ALT = 3'h5;
   localparam logic [2:0] MODE_HALF_ALT = 3'h6;
   localparam logic [2:0] MODE_SLEEP = 3'h7;
   // position increments per mode
   localparam logic [POS_W-1:0] INC_FULL = 6'h10;
   localparam logic [POS_W-1:0] INC_HALF = 6'h08;
   localparam logic [POS_W-1:0] INC_QUARTER = 6'h04;
   localparam logic [POS_W-1:0] INC_EIGHTH = 6'h02;
   localparam logic [POS_W-1:0] INC_SIXTEENTH = 6'h01;
   // synchroniser lanes of the pin vector
   localparam int PIN_W = 9;
   localparam int PIN_CLK = 0;
   localparam int PIN_RST = 1;
   localparam int PIN_DIR = 2;
   localparam int PIN_MODE_LSB = 3;
   localparam int PIN_CHOP = 6;
   localparam int PIN_REF = 7;
   localparam int PIN_FAULT = 8;
   // phase output lanes
   localparam int PH_A = 0;
   localparam int PH_A_N = 1;
   localparam int PH_B = 2;
   localparam int PH_B_N = 3;
endpackage

// file: rtl/ssc_seq.sv
// ssc_seq: clock-in step sequencer of a unipolar two-phase stepper driver.
// assumes all pin inputs are asynchronous to ref_clk_i and are
// synchronised here; the reference comparator arrives as a logic level.
`timescale 1ns/1ps
module ssc_seq #(
   parameter bit DOUBLE_EDGE = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // pins from the controller
   input wire logic step_clk_i,
   input wire logic ext_reset_i,
   input wire logic rotation_direction_i,
   input wire logic step_mode_sel_0_i,
   input wire logic step_mode_sel_1_i,
   input wire logic step_mode_sel_2_i,
   input wire logic chop_sync_i,
   input wire logic ref_above_thresh_i,
   input wire logic fault_detect_i,
   // register port
   input wire logic [ssc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [ssc_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [ssc_pkg::DATA_W-1:0] reg_rdata_o,
   // power stage side
   output logic [3:0] phase_en_o,
   output logic [ssc_pkg::LVL_W-1:0] level_a_o,
   output logic [ssc_pkg::LVL_W-1:0] level_b_o,
   output logic power_stage_en_o,
   output logic chop_sync_en_o,
   output logic step_monitor_out_o,
   output logic fault_flag_o
);
   // whole module state in one record
   typedef struct packed {
      logic [ssc_pkg::PIN_W-1:0] pin_s1;
      logic [ssc_pkg::PIN_W-1:0] pin_s2;
      logic clk_prev;
      logic [ssc_pkg::POS_W-1:0] pos;
      logic [ssc_pkg::STEP_CNT_W-1:0] steps;
      logic force_coast;
      logic [3:0] phase;
      logic [ssc_pkg::LVL_W-1:0] lvl_a;
      logic [ssc_pkg::LVL_W-1:0] lvl_b;
      logic pwr_en;
      logic chop;
      logic monitor;
      logic flag;
      logic [ssc_pkg::DATA_W-1:0] rdata;
   } ssc_state_type;

   // power-on value: sequencer at home, outputs off [RULE1]
   localparam ssc_state_type ST_RESET = '{pos: ssc_pkg::HOME_POS, default: '0};

   // increment for a step mode; sleep code never moves the sequencer
   function automatic logic [ssc_pkg::POS_W-1:0] ssc_step_inc(input logic [2:0] mode);
      logic [ssc_pkg::POS_W-1:0] inc;
      inc = '0;
      unique case (mode)
         ssc_pkg::MODE_FULL: inc = ssc_pkg::INC_FULL;
         ssc_pkg::MODE_FULL_ALT: inc = ssc_pkg::INC_FULL;
         ssc_pkg::MODE_HALF: inc = ssc_pkg::INC_HALF;
         ssc_pkg::MODE_HALF_ALT: inc = ssc_pkg::INC_HALF;
         ssc_pkg::MODE_QUARTER: inc = ssc_pkg::INC_QUARTER;
         ssc_pkg::MODE_EIGHTH: inc = ssc_pkg::INC_EIGHTH;
         ssc_pkg::MODE_SIXTEENTH: inc = ssc_pkg::INC_SIXTEENTH;
         ssc_pkg::MODE_SLEEP: inc = '0;
      endcase
      return inc;
   endfunction

   ssc_state_type q;
   ssc_state_type d;

   logic [ssc_pkg::PIN_W-1:0] pins_raw;
   logic [3:0] rom_phase;
   logic [ssc_pkg::LVL_W-1:0] rom_lvl_a;
   logic [ssc_pkg::LVL_W-1:0] rom_lvl_b;

   // every controller pin enters the same two-stage synchroniser
   assign pins_raw = {fault_detect_i,
                      ref_above_thresh_i,
                      chop_sync_i,
                      step_mode_sel_2_i,
                      step_mode_sel_1_i,
                      step_mode_sel_0_i,
                      rotation_direction_i,
                      ext_reset_i,
                      step_clk_i};

   // excitation table lookup for the current position
   ssc_table_rom u_table (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pos_i(q.pos),
      .phase_o(rom_phase),
      .level_a_o(rom_lvl_a),
      .level_b_o(rom_lvl_b)
   );

   // decoded pin levels, all from the second synchroniser stage
   logic clk_lvl;
   logic rst_lvl;
   logic dir_lvl;
   logic [2:0] mode_lvl;
   logic chop_lvl;
   logic ref_lvl;
   logic fault_lvl;
   assign clk_lvl = q.pin_s2[ssc_pkg::PIN_CLK];
   assign rst_lvl = q.pin_s2[ssc_pkg::PIN_RST];
   assign dir_lvl = q.pin_s2[ssc_pkg::PIN_DIR];
   assign mode_lvl = q.pin_s2[ssc_pkg::PIN_MODE_LSB +: 3];
   assign chop_lvl = q.pin_s2[ssc_pkg::PIN_CHOP];
   assign ref_lvl = q.pin_s2[ssc_pkg::PIN_REF];
   assign fault_lvl = q.pin_s2[ssc_pkg::PIN_FAULT];

   // edge and sleep decoding
   logic clk_rise;
   logic clk_fall;
   logic edge_active;
   logic sleep_ref_disable;
   logic sleep_mode_pins_disable;
   logic outputs_off;
   logic step_take;
   logic [ssc_pkg::POS_W-1:0] inc;

   // only edges count, so a stopped clock at either level holds [RULE6]
   assign clk_rise = clk_lvl && !q.clk_prev;
   assign clk_fall = !clk_lvl && q.clk_prev;
   // falling edges count only on the double-edge variant [RULE5] [RULE15]
   assign edge_active = clk_rise || (DOUBLE_EDGE && clk_fall);

   // comparator level already set near 1.75 V by the analog front end [RULE13]
   assign sleep_ref_disable = ref_lvl; // [RULE11]
   assign sleep_mode_pins_disable = (mode_lvl == ssc_pkg::MODE_SLEEP); // [RULE12] [RULE19]
   assign outputs_off = sleep_ref_disable || sleep_mode_pins_disable || q.force_coast;

   // the mode-pin sleep freezes the sequencer; reference sleep does not
   assign step_take = edge_active && !sleep_mode_pins_disable; // [RULE4] [RULE12]
   assign inc = ssc_step_inc(mode_lvl); // [RULE19]

   // register decode helpers
   logic wr_ctrl;
   logic wr_steps;
   assign wr_ctrl = reg_wr_i && (reg_addr_i == ssc_pkg::REG_CTRL);
   assign wr_steps = reg_wr_i && (reg_addr_i == ssc_pkg::REG_STEPS);

   // status word assembled from live state
   logic [ssc_pkg::DATA_W-1:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[ssc_pkg::ST_POS_LSB +: ssc_pkg::POS_W] = q.pos;
      status_word[ssc_pkg::ST_SLEEP_REF_DISABLE_BIT] = sleep_ref_disable;
      status_word[ssc_pkg::ST_SLEEP_MODE_PINS_DISABLE_BIT] = sleep_mode_pins_disable;
      status_word[ssc_pkg::ST_COAST_BIT] = q.force_coast;
      status_word[ssc_pkg::ST_DIR_BIT] = dir_lvl;
      status_word[ssc_pkg::ST_MODE_LSB +: 3] = mode_lvl;
      status_word[ssc_pkg::ST_CHOP_BIT] = q.chop;
      status_word[ssc_pkg::ST_FAULT_BIT] = fault_lvl;
      status_word[ssc_pkg::ST_HOME_BIT] = (q.pos == ssc_pkg::HOME_POS);
   end

   // next-state logic for the whole block
   always_comb begin
      d = q;

      // two flops on every pin before anything reads it
      d.pin_s1 = pins_raw;
      d.pin_s2 = q.pin_s1;
      // edge history keeps tracking in sleep, so the first edge after
      // wake-up is seen fresh whichever way it goes [RULE15]
      d.clk_prev = clk_lvl;

      // sequencer position
      if (rst_lvl) begin
         // controller re-homes the sequencer; held low when unused [RULE2] [RULE3]
         d.pos = ssc_pkg::HOME_POS;
      end else if (wr_ctrl && reg_wdata_i[ssc_pkg::CTRL_REHOME_BIT]) begin
         // software re-home mirrors the reset pin
         d.pos = ssc_pkg::HOME_POS;
      end else if (step_take) begin
         // one increment per active edge, direction picks the sense [RULE4] [RULE18]
         if (dir_lvl) begin
            d.pos = q.pos + inc;
         end else begin
            d.pos = q.pos - inc;
         end
      end

      // accepted-step counter; a step in the clearing cycle still counts
      if (wr_steps) begin
         d.steps = step_take ? ssc_pkg::STEP_CNT_W'(1) : '0;
      end else if (step_take) begin
         d.steps = q.steps + ssc_pkg::STEP_CNT_W'(1);
      end

      // software coast bit
      if (wr_ctrl) begin
         d.force_coast = reg_wdata_i[ssc_pkg::CTRL_COAST_BIT];
      end

      // outputs: both sleeps coast and stop the power stage [RULE11] [RULE12]
      if (outputs_off) begin
         d.phase = '0;
         d.lvl_a = '0;
         d.lvl_b = '0;
         d.pwr_en = 1'b0;
      end else begin
         d.phase = rom_phase;
         d.lvl_a = rom_lvl_a;
         d.lvl_b = rom_lvl_b;
         d.pwr_en = 1'b1;
      end

      // synchronized chopping follows the pin level, held off while outputs are off [RULE7]
      d.chop = chop_lvl && !outputs_off;

      // monitor marks the home position, flag mirrors the fault level
      d.monitor = (q.pos == ssc_pkg::HOME_POS);
      d.flag = fault_lvl;

      // read data live only in the cycle after the strobe
      d.rdata = '0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            ssc_pkg::REG_CTRL: begin
               d.rdata[ssc_pkg::CTRL_COAST_BIT] = q.force_coast;
            end
            ssc_pkg::REG_STATUS: begin
               d.rdata = status_word;
            end
            ssc_pkg::REG_STEPS: begin
               d.rdata[ssc_pkg::STEP_CNT_W-1:0] = q.steps;
            end
            default: begin
               d.rdata = '0; // unmapped reads answer zero
            end
         endcase
      end
   end

   // single state register, asynchronous power-on reset [RULE1]
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   // every output straight from the state register; monitor and flag are
   // always driven, so leaving them open is harmless [RULE17]
   assign reg_rdata_o = q.rdata;
   assign phase_en_o = q.phase;
   assign level_a_o = q.lvl_a;
   assign level_b_o = q.lvl_b;
   assign power_stage_en_o = q.pwr_en;
   assign chop_sync_en_o = q.chop;
   assign step_monitor_out_o = q.monitor;
   assign fault_flag_o = q.flag;
endmodule

// file: rtl/ssc_table_rom.sv
// ssc_table_rom: excitation table, position in, phase and current levels out.
// assumes index comes from logic on the same clock; output is one cycle late.
`timescale 1ns/1ps
module ssc_table_rom (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [ssc_pkg::POS_W-1:0] pos_i,
   output logic [3:0] phase_o,
   output logic [ssc_pkg::LVL_W-1:0] level_a_o,
   output logic [ssc_pkg::LVL_W-1:0] level_b_o
);
   // quarter-wave sine, 17 points, full scale 15
   function automatic logic [ssc_pkg::LVL_W-1:0] ssc_quarter(input logic [4:0] k);
      logic [ssc_pkg::LVL_W-1:0] v;
      v = 4'hF;
      case (k)
         5'h00: v = 4'h0;
         5'h01: v = 4'h1;
         5'h02: v = 4'h3;
         5'h03: v = 4'h4;
         5'h04: v = 4'h6;
         5'h05: v = 4'h7;
         5'h06: v = 4'h8;
         5'h07: v = 4'hA;
         5'h08: v = 4'hB;
         5'h09: v = 4'hC;
         5'h0A: v = 4'hC;
         5'h0B: v = 4'hD;
         5'h0C: v = 4'hE;
         5'h0D: v = 4'hE;
         default: v = 4'hF;
      endcase
      return v;
   endfunction

   logic [1:0] quad;
   logic [4:0] frac;
   logic [4:0] frac_c;
   assign quad = pos_i[5:4];
   assign frac = {1'b0, pos_i[3:0]};
   assign frac_c = 5'h10 - frac;

   // phase a follows cosine, phase b sine; sign picks the coil half
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_o <= 4'h0;
         level_a_o <= 4'h0;
         level_b_o <= 4'h0;
      end else begin
         level_a_o <= quad[0] ? ssc_quarter(frac) : ssc_quarter(frac_c);
         level_b_o <= quad[0] ? ssc_quarter(frac_c) : ssc_quarter(frac);
         phase_o[ssc_pkg::PH_A] <= (quad == 2'h0) || (quad == 2'h3);
         phase_o[ssc_pkg::PH_A_N] <= (quad == 2'h1) || (quad == 2'h2);
         phase_o[ssc_pkg::PH_B] <= !quad[1];
         phase_o[ssc_pkg::PH_B_N] <= quad[1];
      end
   end
endmodule

// file: verif/ssc_checker.sv
// ssc_checker: port-level properties of the step sequencer.
// assumes it is bound to every ssc_seq instance and sees only its ports.
`timescale 1ns/1ps
module ssc_checker (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic step_clk_i,
   input wire logic ext_reset_i,
   input wire logic step_mode_sel_0_i,
   input wire logic step_mode_sel_1_i,
   input wire logic step_mode_sel_2_i,
   input wire logic chop_sync_i,
   input wire logic ref_above_thresh_i,
   input wire logic fault_detect_i,
   input wire logic reg_wr_i,
   input wire logic [3:0] phase_en_o,
   input wire logic [ssc_pkg::LVL_W-1:0] level_a_o,
   input wire logic power_stage_en_o,
   input wire logic chop_sync_en_o,
   input wire logic step_monitor_out_o,
   input wire logic fault_flag_o
);
   logic [2:0] mode;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   // mode code as the pins present it
   assign mode = {step_mode_sel_2_i, step_mode_sel_1_i, step_mode_sel_0_i};

   // nothing that could move the outputs changes in this cycle
   sequence s_quiet;
      $stable(step_clk_i) && $stable(ref_above_thresh_i) && $stable(mode)
         && $stable(ext_reset_i) && $stable(fault_detect_i)
         && $stable(chop_sync_i) && !reg_wr_i;
   endsequence
   // chop request with the stage awake; six cycles cover the synchroniser
   sequence s_awake_chop;
      (chop_sync_i && !ref_above_thresh_i && mode != 3'h7) [*6];
   endsequence

   a_por_home: assert property ($rose(nrst_i) |-> ##[1:2] step_monitor_out_o)
      else $error("monitor not at home after reset");
   a_rehome_mon: assert property (ext_reset_i [*6] |-> step_monitor_out_o)
      else $error("re-home pin did not return home");
   a_hold_stable: assert property (s_quiet [*8] |-> $stable(phase_en_o) && $stable(level_a_o))
      else $error("outputs moved with no step edge");
   a_chop_on: assert property (s_awake_chop |-> chop_sync_en_o)
      else $error("chop sync not enabled");
   a_chop_off: assert property (!chop_sync_i [*4] |-> !chop_sync_en_o)
      else $error("chop sync enabled without request");
   a_ref_coast: assert property (ref_above_thresh_i [*6] |-> !power_stage_en_o && phase_en_o == 4'h0)
      else $error("reference sleep did not coast");
   a_mode_coast: assert property ((mode == 3'h7) [*6] |-> !power_stage_en_o && level_a_o == 4'h0)
      else $error("mode sleep did not coast");
   a_fault_flag: assert property (fault_detect_i [*4] |-> fault_flag_o)
      else $error("fault flag not driven high");
   a_fault_clear: assert property (!fault_detect_i [*4] |-> !fault_flag_o)
      else $error("fault flag not driven low");
endmodule

bind ssc_seq ssc_checker ssc_checker_inst (.ref_clk_i, .nrst_i, .step_clk_i, .ext_reset_i,
   .step_mode_sel_0_i, .step_mode_sel_1_i, .step_mode_sel_2_i, .chop_sync_i,
   .ref_above_thresh_i, .fault_detect_i, .reg_wr_i, .phase_en_o, .level_a_o,
   .power_stage_en_o, .chop_sync_en_o, .step_monitor_out_o, .fault_flag_o);

// file: verif/ssc_mcu_model.sv
// ssc_mcu_model: controller that drives the step, reset and mode pins.
// assumes the bench calls its tasks one at a time from a single thread.
`timescale 1ns/1ps
module ssc_mcu_model (
   input wire logic ref_clk_i,
   output logic step_clk_o,
   output logic ext_reset_o,
   output logic dir_o,
   output logic [2:0] mode_o,
   output logic ref_o,
   output logic chop_o
);
   // defined levels from time zero; no pin is ever left open
   initial begin
      step_clk_o = 1'b0; // clock rests low so idle is seen as idle
      ext_reset_o = 1'b0; // reset held low while not re-homing
      dir_o = 1'b1;
      mode_o = 3'h0;
      ref_o = 1'b0;
      chop_o = 1'b0;
   end

   // one level change, held long enough for the synchroniser
   task automatic edge_to(input logic v);
      @(posedge ref_clk_i);
      step_clk_o <= v;
      repeat (3) @(posedge ref_clk_i);
   endtask

   task automatic pulses(input int n);
      @(posedge ref_clk_i);
      chop_o <= 1'b0; // sync chop stays off while the motor turns
      for (int i = 0; i < n; i++) begin
         edge_to(1'b1);
         edge_to(1'b0);
      end
   endtask

   task automatic set_cfg(input logic [2:0] m, input logic d, input logic r, input logic c);
      @(posedge ref_clk_i);
      mode_o <= m;
      dir_o <= d;
      ref_o <= r;
      chop_o <= c;
      // settle time also serves as the wake-up delay after sleep
      repeat (12) @(posedge ref_clk_i);
   endtask

   // chop request from clock idleness: a whole timeout low means hold
   task automatic chop_on_idle(input int timeout);
      int low_cyc;
      low_cyc = 0;
      while (low_cyc < timeout) begin
         @(posedge ref_clk_i);
         low_cyc = step_clk_o ? 0 : low_cyc + 1;
      end
      chop_o <= 1'b1;
   endtask

   task automatic rehome;
      @(posedge ref_clk_i);
      ext_reset_o <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      ext_reset_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule

// file: verif/testbench.sv
// testbench: standard and double-edge sequencers driven side by side.
// assumes both share every input; positions are read through status.
`timescale 1ns/1ps
module testbench;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic fault = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic stp, xrst, dir, chop, refh, pwr, chp, mon, flg;
   logic [2:0] mode;
   logic [3:0] ph, la, lb;
   logic [31:0] rdata_s, rdata_d, rs, rw;
   logic [5:0] ps, pd;
   logic [2:0] m_cur = 3'h0;
   logic d_cur = 1'b1;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   int nst = 0;
   int n;

   ssc_mcu_model ssc_mcu_model_inst (.ref_clk_i, .step_clk_o(stp), .ext_reset_o(xrst),
      .dir_o(dir), .mode_o(mode), .ref_o(refh), .chop_o(chop));
   ssc_seq ssc_seq_inst (.ref_clk_i, .nrst_i, .step_clk_i(stp), .ext_reset_i(xrst),
      .rotation_direction_i(dir), .step_mode_sel_0_i(mode[0]), .step_mode_sel_1_i(mode[1]),
      .step_mode_sel_2_i(mode[2]), .chop_sync_i(chop), .ref_above_thresh_i(refh),
      .fault_detect_i(fault), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata_s), .phase_en_o(ph), .level_a_o(la), .level_b_o(lb),
      .power_stage_en_o(pwr), .chop_sync_en_o(chp), .step_monitor_out_o(mon),
      .fault_flag_o(flg));
   // double-edge twin; only its register port is compared
   ssc_seq #(.DOUBLE_EDGE(1'b1)) ssc_seq_dual_inst (.ref_clk_i, .nrst_i, .step_clk_i(stp),
      .ext_reset_i(xrst), .rotation_direction_i(dir), .step_mode_sel_0_i(mode[0]),
      .step_mode_sel_1_i(mode[1]), .step_mode_sel_2_i(mode[2]), .chop_sync_i(chop),
      .ref_above_thresh_i(refh), .fault_detect_i(fault), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_d),
      .phase_en_o(), .level_a_o(), .level_b_o(), .power_stage_en_o(), .chop_sync_en_o(),
      .step_monitor_out_o(), .fault_flag_o());

   // 125 MHz clock and a cycle ceiling that cuts a hang short
   always #4 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   function automatic logic [5:0] inc(input logic [2:0] m);
      case (m)
         3'h0, 3'h5: inc = ssc_pkg::INC_FULL;
         3'h1, 3'h6: inc = ssc_pkg::INC_HALF;
         3'h2: inc = ssc_pkg::INC_QUARTER;
         3'h3: inc = ssc_pkg::INC_EIGHTH;
         3'h4: inc = ssc_pkg::INC_SIXTEENTH;
         default: inc = 6'h00; // frozen: no edge is taken
      endcase
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // register port: strobes last one cycle, read data stand the cycle after
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1;
      rs = rdata_s;
      rw = rdata_d;
   endtask

   // a rising edge counts once, a falling edge only on the twin
   task automatic adv(input int a, input int b);
      ps = d_cur ? ps + a * inc(m_cur) : ps - a * inc(m_cur);
      pd = d_cur ? pd + b * inc(m_cur) : pd - b * inc(m_cur);
   endtask

   task automatic move(input int k);
      ssc_mcu_model_inst.pulses(k);
      adv(k, 2 * k);
   endtask

   task automatic cfg(input logic [2:0] m, input logic d, input logic r, input logic c);
      m_cur = m;
      d_cur = d;
      ssc_mcu_model_inst.set_cfg(m, d, r, c);
      #1;
   endtask

   task automatic chk_pos;
      repeat (6) @(posedge ref_clk_i);
      reg_rd(ssc_pkg::REG_STATUS);
      check("pos", rs[5:0], ps);
      check("pos_dual", rw[5:0], pd);
   endtask

   initial begin
      ps = ssc_pkg::HOME_POS;
      pd = ssc_pkg::HOME_POS;
      void'($urandom(32'hA5B2));
      repeat (16) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
      check("monitor", mon, 1'b1);
      check("home_ph", {pwr, ph}, 5'h15);
      chk_pos();
      check("home", rs[ssc_pkg::ST_HOME_BIT], 1'b1);
      // every resolution code, random direction and step count
      reg_wr(ssc_pkg::REG_STEPS, 32'h0);
      for (int i = 0; i < 7; i++) begin
         n = $urandom_range(4, 1);
         cfg(i[2:0], 1'($urandom), 1'b0, 1'b0);
         move(n);
         nst += n;
         chk_pos();
         check("mode", rs[14:12], m_cur);
         check("dir", rs[ssc_pkg::ST_DIR_BIT], d_cur);
      end
      reg_rd(ssc_pkg::REG_STEPS);
      check("steps", rs[15:0], nst);
      check("steps_dual", rw[15:0], 2 * nst);
      // clock left high, then falling: only the twin moves on the fall
      ssc_mcu_model_inst.edge_to(1'b1);
      adv(1, 1);
      repeat (30) @(posedge ref_clk_i);
      chk_pos();
      ssc_mcu_model_inst.edge_to(1'b0);
      adv(0, 1);
      chk_pos();
      // reference sleep coasts but keeps stepping
      cfg(3'h0, 1'b1, 1'b1, 1'b0);
      check("coast", {pwr, ph}, 5'h00);
      move(2);
      chk_pos();
      check("sleep_ref_disable", rs[ssc_pkg::ST_SLEEP_REF_DISABLE_BIT], 1'b1);
      cfg(3'h0, 1'b1, 1'b0, 1'b0);
      check("awake", pwr, 1'b1);
      // mode sleep freezes; a fall after waking still counts on the twin
      cfg(3'h7, 1'b1, 1'b0, 1'b0);
      check("coast2", {pwr, la, lb}, 9'h000);
      move(2);
      ssc_mcu_model_inst.edge_to(1'b1);
      chk_pos();
      cfg(3'h0, 1'b1, 1'b0, 1'b0);
      ssc_mcu_model_inst.edge_to(1'b0);
      adv(0, 1);
      chk_pos();
      // chop sync follows its pin and drops in sleep
      ssc_mcu_model_inst.chop_on_idle(8);
      repeat (6) @(posedge ref_clk_i);
      #1;
      check("chop", chp, 1'b1);
      cfg(3'h0, 1'b1, 1'b1, 1'b1);
      check("chop_sleep", chp, 1'b0);
      cfg(3'h0, 1'b1, 1'b0, 1'b0);
      @(posedge ref_clk_i);
      fault <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      #1;
      check("flag", flg, 1'b1);
      @(posedge ref_clk_i);
      fault <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      #1;
      check("flag_off", flg, 1'b0);
      // re-home after running, then home position and monitor checked
      ssc_mcu_model_inst.rehome();
      ps = ssc_pkg::HOME_POS;
      pd = ssc_pkg::HOME_POS;
      chk_pos();
      check("mon_home", mon, 1'b1);
      // software coast reads back, then a software re-home clears it
      reg_wr(ssc_pkg::REG_CTRL, 32'h2);
      reg_rd(ssc_pkg::REG_CTRL);
      check("coast_sw", {rs[1:0], pwr}, 3'h4);
      move(1);
      reg_wr(ssc_pkg::REG_CTRL, 32'h1);
      ps = ssc_pkg::HOME_POS;
      pd = ssc_pkg::HOME_POS;
      chk_pos();
      check("awake_sw", pwr, 1'b1);
      reg_rd(4'hC);
      check("unmapped", rs, 32'h0);
      tally_and_finish();
   end
endmodule
